//--- hw/rsb_reset_boot.sv
`timescale 1ns/1ps
module rsb_reset_boot
    import rsb_pkg::*;
#(
    parameter int WDT_DIV    = WDT_DIV_DEFAULT,
    parameter int GRACE      = WDT_GRACE_TICKS,
    parameter int HOLD       = RESET_HOLD_CYCLES
)(
    // clock and power-on reset
    input  wire logic        clk,
    input  wire logic        srst,
    // other reset requests, one cycle
    input  wire logic        ext_reset_req,
    // register port
    input  wire logic [7:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [7:0]  reg_rdata,
    // system reset and boot outcome
    output logic             sys_reset,
    output logic             cpu_halt,
    output logic             boot_loader,
    output rsb_state_s       mach_state,
    output logic             ram_keep
);

    // unlock window and watchdog state
    logic [1:0]  unlock_stage;
    logic        wdt_run;
    logic        wdt_tof;
    logic [2:0]  wdt_sel;
    logic [15:0] div_cnt;
    logic        tick;
    logic [19:0] wdt_cnt;
    logic [15:0] grace_cnt;

    // reset causes and boot outcome
    logic        wdt_flag;
    logic        sw_flag;
    logic        sw_trigger;
    logic        boot_sel;
    logic [7:0]  boot_cfg;

    // reset sequencer
    logic [3:0]  hold_cnt;
    logic        pending_sw;
    logic        pending_wdt;
    logic        any_req;
    logic        wdt_expire;
    logic        sw_fire;
    logic        release_now;

    // per-register write strobes, decoded once and shared
    logic        wr_chip;
    logic        wr_chip_open;
    logic        wr_aux;
    logic        wr_unlock;
    logic        wr_wdt_ctrl;
    logic        wr_wdt_presc;
    logic        wr_cfg;
    logic        wdt_clear;

    // read images of each register
    logic [7:0]  rd_chip;
    logic [7:0]  rd_aux;
    logic [7:0]  rd_wdt_ctrl;
    logic [7:0]  rd_wdt_presc;
    logic [7:0]  rd_unlock;
    logic [7:0]  next_rdata;

    // decode shared by write paths
    function automatic logic hit(input logic [7:0] a, input logic [7:0] t);
        hit = (a == t);
    endfunction

    // time-out length by select field, 2^(6+sel) ticks
    function automatic logic [19:0] timeout_of(input logic [2:0] s);
        timeout_of = 20'(20'h00040 << s);
    endfunction

    // unlock window open: the last two writes were the unlock pair
    function automatic logic unlock_open(input logic [1:0] st);
        unlock_open = (st == 2'h2);
    endfunction

    // write strobes by register; a read never changes state
    assign wr_chip      = reg_wr && hit(reg_addr, ADDR_CHIP_CONTROL);
    assign wr_chip_open = wr_chip && unlock_open(unlock_stage);
    assign wr_aux       = reg_wr && hit(reg_addr, ADDR_AUX_FLAGS);
    assign wr_unlock    = reg_wr && hit(reg_addr, ADDR_TIMED_ACCESS);
    assign wr_wdt_ctrl  = reg_wr && hit(reg_addr, ADDR_WATCHDOG_CTRL);
    assign wr_wdt_presc = reg_wr && hit(reg_addr, ADDR_WATCHDOG_PRESC);
    assign wr_cfg       = reg_wr && hit(reg_addr, ADDR_BOOT_CONFIG);
    assign wdt_clear    = wr_wdt_ctrl && reg_wdata[WDC_CLR_BIT];

    // reset requests; one still running swallows any new one
    assign sw_fire     = wr_chip_open && reg_wdata[CHPC_SOFTWARE_RESET_TRIGGER_BIT];
    assign wdt_expire  = wdt_tof && (grace_cnt == 16'(GRACE - 1)) && tick;
    assign any_req     = ext_reset_req || sw_fire || wdt_expire;
    assign release_now = sys_reset && (hold_cnt == 4'h0);

    // timed-access unlock: aa then 55, must be the next write before trigger
    // the window stays open over idle cycles and closes on the next write of any kind
    always_ff @(posedge clk)
    begin
        if (srst || sys_reset)
            unlock_stage <= 2'h0;
        else if (reg_wr)
        begin
            if (wr_unlock && reg_wdata == UNLOCK_FIRST)
                unlock_stage <= 2'h1;
            else if (wr_unlock && reg_wdata == UNLOCK_SECOND && unlock_stage == 2'h1)
                unlock_stage <= 2'h2;
            else
                unlock_stage <= 2'h0;   // any other write breaks the window
        end
    end

    // watchdog tick divider, stands in for its private oscillator
    always_ff @(posedge clk)
    begin
        if (srst || div_cnt == 16'(WDT_DIV - 1))
            div_cnt <= 16'h0000;
        else
            div_cnt <= div_cnt + 16'h0001;
    end
    // limitation: tick follows clk, so the watchdog stops when the system clock does
    assign tick = (div_cnt == 16'(WDT_DIV - 1));

    // watchdog count, free running while enabled; a clear restarts it
    // the count parks at the limit while the response window runs
    always_ff @(posedge clk)
    begin
        if (srst || sys_reset || !wdt_run || wdt_clear)
            wdt_cnt <= 20'h00000;
        else if (tick && !wdt_tof && wdt_cnt != timeout_of(wdt_sel) - 20'h00001)
            wdt_cnt <= wdt_cnt + 20'h00001;
    end

    // time-out flag raised at the end of the selected interval
    always_ff @(posedge clk)
    begin
        if (srst || sys_reset || !wdt_run || wdt_clear)
            wdt_tof <= 1'b0;
        else if (tick && !wdt_tof && wdt_cnt == timeout_of(wdt_sel) - 20'h00001)
            wdt_tof <= 1'b1;
    end

    // response window, whole ticks after the time-out flag
    always_ff @(posedge clk)
    begin
        if (srst || sys_reset || !wdt_run || wdt_clear)
            grace_cnt <= 16'h0000;
        else if (tick && wdt_tof)
            grace_cnt <= grace_cnt + 16'h0001;
    end

    // watchdog enable, cleared by any reset
    always_ff @(posedge clk)
    begin
        if (srst || sys_reset)
            wdt_run <= 1'b0;
        else if (wr_wdt_ctrl)
            wdt_run <= reg_wdata[WDC_RUN_BIT];
    end

    // time-out select, back to the shortest interval on any reset
    always_ff @(posedge clk)
    begin
        if (srst || sys_reset)
            wdt_sel <= WDT_SEL_RESET;
        else if (wr_wdt_presc)
            wdt_sel <= reg_wdata[2:0];
    end

    // merged internal reset, raised by any request, dropped when the hold runs out
    // a request that lands during a running reset is dropped, not queued
    always_ff @(posedge clk)
    begin
        if (srst || (any_req && !sys_reset))
            sys_reset <= 1'b1;
        else if (release_now)
            sys_reset <= 1'b0;
    end

    // hold counter, fixed length whatever the source
    // power-on loads it too, so its release matches every other reset
    always_ff @(posedge clk)
    begin
        if (srst || (any_req && !sys_reset))
            hold_cnt <= 4'(HOLD - 1);
        else if (sys_reset && hold_cnt != 4'h0)
            hold_cnt <= hold_cnt - 4'h1;
    end

    // cause of the running reset, kept until release so boot select skips a software reset
    always_ff @(posedge clk)
    begin
        if (srst || release_now)
        begin
            pending_sw  <= 1'b0;
            pending_wdt <= 1'b0;
        end
        else if (any_req && !sys_reset)
        begin
            pending_sw  <= sw_fire;
            pending_wdt <= wdt_expire;
        end
    end

    // halt fetch the cycle after the trigger write
    // halt rises on the request edge so no later instruction completes
    always_ff @(posedge clk)
    begin
        if (srst)
            cpu_halt <= 1'b1;
        else
            cpu_halt <= any_req || (sys_reset && hold_cnt != 4'h0);
    end

    // trigger bit visible until reset finishes, then cleared
    // reads back high through the hold, so software can see the reset pending
    always_ff @(posedge clk)
    begin
        if (srst)
            sw_trigger <= 1'b0;
        else if (sw_fire)
            sw_trigger <= 1'b1;
        else if (release_now)
            sw_trigger <= 1'b0;
    end

    // watchdog cause flag, set wins over a software clear
    // clears during a running reset are ignored so a cause is never lost
    always_ff @(posedge clk)
    begin
        if (srst)
            wdt_flag <= 1'b0;
        else if (wdt_expire)
            wdt_flag <= 1'b1;
        else if (wr_wdt_ctrl && !sys_reset)
            wdt_flag <= reg_wdata[WDC_RF_BIT];
    end

    // software cause flag, same set-over-clear priority
    always_ff @(posedge clk)
    begin
        if (srst)
            sw_flag <= 1'b0;
        else if (sw_fire)
            sw_flag <= 1'b1;
        else if (wr_aux && !sys_reset)
            sw_flag <= reg_wdata[AUX_SOFTWARE_RESET_FLAG_BIT];
    end

    // config byte, factory ones; writable stand-in for flash
    // a write here lasts until power-on, like a programmed byte
    always_ff @(posedge clk)
    begin
        if (srst)
            boot_cfg <= BOOT_CONFIG_DEFAULT;
        else if (wr_cfg)
            boot_cfg <= reg_wdata;
    end

    // boot select: reload from inverted config except after software reset
    // srst comes first so power-on always reloads
    always_ff @(posedge clk)
    begin
        if (srst || (sys_reset && !pending_sw))
            boot_sel <= ~boot_cfg[CFG_CBS_BIT];
        else if (wr_chip_open)
            boot_sel <= reg_wdata[CHPC_BS_BIT];
    end

    // boot block latched from boot select at release only
    always_ff @(posedge clk)
    begin
        if (release_now)
            boot_loader <= boot_sel;
        else if (srst)
            boot_loader <= 1'b0;
    end

    // machine state held at reset values while reset applies
    // forced only; the processor core owns these values between resets
    always_ff @(posedge clk)
    begin
        if (srst || sys_reset)
        begin
            mach_state.pc              <= PC_RESET;
            mach_state.sp              <= SP_RESET;
            mach_state.port_latch      <= PORT_LATCH_RESET;
            mach_state.port_input_only <= 1'b1;
            mach_state.periph_enable   <= 1'b0;
        end
    end

    // ram survives every reset except power-on
    // a level for the memory controller, low only while power-on reset is fresh
    always_ff @(posedge clk)
    begin
        if (srst)
            ram_keep <= 1'b0;
        else
            ram_keep <= 1'b1;
    end

    // read images; unused and write-only bits read zero
    assign rd_chip      = {sw_trigger, 5'h00, boot_sel, 1'b0};
    assign rd_aux       = {sw_flag, 7'h00};
    assign rd_wdt_ctrl  = {wdt_run, 1'b0, wdt_tof, 1'b0, wdt_flag, 3'h0};
    assign rd_wdt_presc = {5'h00, wdt_sel};
    assign rd_unlock    = {6'h00, unlock_stage};

    // read data, one cycle after the strobe; unmapped reads zero
    // reads have no side effects, so polling a flag never loses it
    always_comb
    begin
        next_rdata = 8'h00;
        case (reg_addr)
            ADDR_CHIP_CONTROL:   next_rdata = rd_chip;
            ADDR_AUX_FLAGS:      next_rdata = rd_aux;
            ADDR_WATCHDOG_CTRL:  next_rdata = rd_wdt_ctrl;
            ADDR_WATCHDOG_PRESC: next_rdata = rd_wdt_presc;
            ADDR_BOOT_CONFIG:    next_rdata = boot_cfg;
            ADDR_TIMED_ACCESS:   next_rdata = rd_unlock;
            default:             next_rdata = 8'h00;   // covers every unmapped address
        endcase
    end

    // read register, zero outside the answer cycle
    always_ff @(posedge clk)
    begin
        if (srst)
            reg_rdata <= 8'h00;
        else if (reg_rd)
            reg_rdata <= next_rdata;
        else
            reg_rdata <= 8'h00;
    end

endmodule

//--- hw/rsb_pkg.sv
package rsb_pkg;

    // register addresses on the 8-bit special function bus
    localparam logic [7:0] ADDR_CHIP_CONTROL   = 8'h9F;
    localparam logic [7:0] ADDR_AUX_FLAGS      = 8'hA2;
    localparam logic [7:0] ADDR_TIMED_ACCESS   = 8'hC7;
    localparam logic [7:0] ADDR_WATCHDOG_CTRL  = 8'hAA;
    localparam logic [7:0] ADDR_WATCHDOG_PRESC = 8'hAB;
    localparam logic [7:0] ADDR_BOOT_CONFIG    = 8'hAC;

    // field positions
    localparam int CHPC_SOFTWARE_RESET_TRIGGER_BIT = 7;
    localparam int CHPC_BS_BIT    = 1;
    localparam int AUX_SOFTWARE_RESET_FLAG_BIT   = 7;
    localparam int WDC_RUN_BIT    = 7;
    localparam int WDC_CLR_BIT    = 6;
    localparam int WDC_TOF_BIT    = 5;
    localparam int WDC_RF_BIT     = 3;
    localparam int CFG_CBS_BIT    = 7;

    // reset values and unlock codes
    localparam logic [7:0] BOOT_CONFIG_DEFAULT = 8'hFF;
    localparam logic [7:0] UNLOCK_FIRST        = 8'hAA;
    localparam logic [7:0] UNLOCK_SECOND       = 8'h55;
    localparam logic [2:0] WDT_SEL_RESET       = 3'h0;
    localparam logic [15:0] PC_RESET           = 16'h0000;
    localparam logic [7:0] SP_RESET            = 8'h07;
    localparam logic [7:0] PORT_LATCH_RESET    = 8'hFF;

    // timing
    localparam int WDT_DIV_DEFAULT    = 100;  // internal watchdog tick every 10 us
    localparam int WDT_GRACE_TICKS    = 256;  // response window after time-out
    localparam int RESET_HOLD_CYCLES  = 4;    // internal reset pulse length

    typedef enum logic [1:0] {RSB_BOOT_APP, RSB_BOOT_LOADER} rsb_boot_e;

    // bundle of machine state forced during reset
    typedef struct packed {
        logic [15:0] pc;
        logic [7:0]  sp;
        logic [7:0]  port_latch;
        logic        port_input_only;
        logic        periph_enable;
    } rsb_state_s;

endpackage

//--- tb/rsb_reset_boot_sva.sv
`timescale 1ns/1ps
module rsb_reset_boot_sva
    import rsb_pkg::*;
(
    // clock and power-on reset
    input wire logic       clk,
    input wire logic       srst,
    // requests and register writes
    input wire logic       ext_reset_req,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_wr,
    // reset outcome
    input wire logic       sys_reset,
    input wire logic       cpu_halt,
    input wire rsb_state_s mach_state,
    input wire logic       ram_keep
);
    // unlock and trigger writes decoded once
    wire ta_one = reg_wr && reg_addr == ADDR_TIMED_ACCESS && reg_wdata == UNLOCK_FIRST;
    wire ta_two = reg_wr && reg_addr == ADDR_TIMED_ACCESS && reg_wdata == UNLOCK_SECOND;
    wire trig   = reg_wr && reg_addr == ADDR_CHIP_CONTROL && reg_wdata[CHPC_SOFTWARE_RESET_TRIGGER_BIT];

    default clocking @(posedge clk); endclocking
    default disable iff (srst);

    chk_sw_trigger: assert property (trig && !sys_reset && $past(ta_two) && $past(ta_one, 2) |=> sys_reset)
        else $error("unlocked trigger gave no reset");
    chk_sw_locked: assert property (trig && !sys_reset && !ext_reset_req && $past(reg_wr) && !$past(ta_two)
        |=> !sys_reset)
        else $error("locked trigger still reset");
    chk_ext_merge: assert property (ext_reset_req && !sys_reset |=> sys_reset && cpu_halt && ram_keep)
        else $error("request did not merge into reset");
    chk_hold_len: assert property ($rose(sys_reset) |-> sys_reset [*4] ##1 !sys_reset)
        else $error("reset pulse length wrong");
    // release length allows for the registered power-on stage
    chk_por_release: assert property ($fell(srst) |-> sys_reset [*3] ##[1:3] !sys_reset)
        else $error("power-on release length wrong");
    chk_pc_sp: assert property (sys_reset && $past(sys_reset) |-> mach_state.pc == PC_RESET
        && mach_state.sp == SP_RESET)
        else $error("pc or sp not forced in reset");
    chk_port_state: assert property (sys_reset && $past(sys_reset) |-> mach_state.port_latch == PORT_LATCH_RESET
        && mach_state.port_input_only && !mach_state.periph_enable)
        else $error("ports or peripherals not forced");
    chk_halt_span: assert property (sys_reset |-> cpu_halt)
        else $error("cpu running during reset");
endmodule

bind rsb_reset_boot rsb_reset_boot_sva u_sva (.clk(clk), .srst(srst), .ext_reset_req(ext_reset_req),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .sys_reset(sys_reset),
    .cpu_halt(cpu_halt), .mach_state(mach_state), .ram_keep(ram_keep));

//--- tb/rsb_reset_boot_tb_top.sv
`timescale 1ns/1ps
module rsb_reset_boot_tb_top
    import rsb_pkg::*;
;
    logic       clk, srst, ext_reset_req, reg_wr, reg_rd;
    logic       sys_reset, cpu_halt, boot_loader, ram_keep;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, v;
    rsb_state_s mach_state;
    int         failures, cmp_count, n;

    // short watchdog tick and grace keep the run brief
    rsb_reset_boot #(.WDT_DIV(2), .GRACE(2)) u_dut (.clk(clk), .srst(srst), .ext_reset_req(ext_reset_req),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .sys_reset(sys_reset), .cpu_halt(cpu_halt), .boot_loader(boot_loader), .mach_state(mach_state),
        .ram_keep(ram_keep));

    // 100 ns clock
    initial
    begin
        clk = 1'h0;
        forever #50 clk = ~clk;
    end

    task chk(input string nm, input logic [39:0] s, input logic [39:0] e);
        cmp_count++;
        if (s !== e)
        begin
            failures++;
            $display("ERROR %s expected %0h seen %0h", nm, e, s);
        end
    endtask

    task close_out;
        $display("compares %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // strobe stays up so writes can run back to back
    task bus(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_wr <= w;
        reg_rd <= !w;
        reg_addr <= a;
        reg_wdata <= d;
    endtask

    task idle;
        @(posedge clk);
        reg_wr <= 1'h0;
        reg_rd <= 1'h0;
    endtask

    task wr(input logic [7:0] a, input logic [7:0] d);
        bus(1'h1, a, d);
        idle;
    endtask

    // read data stand only in the cycle after the strobe
    task rd(input logic [7:0] a);
        bus(1'h0, a, 8'h00);
        idle;
        #1 v = reg_rdata;
    endtask

    task uwr(input logic [7:0] a, input logic [7:0] d);
        bus(1'h1, ADDR_TIMED_ACCESS, UNLOCK_FIRST);
        bus(1'h1, ADDR_TIMED_ACCESS, UNLOCK_SECOND);
        bus(1'h1, a, d);
        idle;
    endtask

    // check forced state mid-reset, then wait for release
    task rel;
        repeat (2) @(posedge clk);
        #1 chk("state", mach_state, {PC_RESET, SP_RESET, PORT_LATCH_RESET, 2'h2});
        n = 0;
        while (sys_reset !== 1'h0 && n < 20)
        begin
            @(posedge clk);
            #1 n++;
        end
        if (n >= 20)
        begin
            failures++;
            close_out;
        end
    endtask

    task xrst;
        @(posedge clk) ext_reset_req <= 1'h1;
        @(posedge clk) ext_reset_req <= 1'h0;
        #1 chk("ext", {sys_reset, cpu_halt, ram_keep}, 3'h7);
        rel;
    endtask

    task software_reset_trigger(input logic [7:0] d);
        uwr(ADDR_CHIP_CONTROL, d);
        #1 chk("sw", {sys_reset, cpu_halt}, 2'h3);
        rel;
    endtask

    task t_por;
        rd(ADDR_AUX_FLAGS);
        chk("swf", v[7], 1'h0);
        rd(ADDR_WATCHDOG_CTRL);
        chk("wdf", v[3], 1'h0);
        chk("boot", boot_loader, 1'h0);
        $display("power-on test done");
    endtask

    task t_sw;
        bus(1'h1, ADDR_TIMED_ACCESS, UNLOCK_SECOND);
        bus(1'h1, ADDR_CHIP_CONTROL, 8'h80);
        idle;
        repeat (2) @(posedge clk);
        #1 chk("locked", sys_reset, 1'h0);
        software_reset_trigger(8'h80);
        rd(ADDR_CHIP_CONTROL);
        chk("trig", v[7], 1'h0);
        rd(ADDR_AUX_FLAGS);
        chk("swf", v[7], 1'h1);
        rd(ADDR_WATCHDOG_CTRL);
        chk("wdf", v[3], 1'h0);
        $display("software reset test done");
    endtask

    task t_boot;
        uwr(ADDR_CHIP_CONTROL, 8'h02);
        software_reset_trigger(8'h82);
        chk("boot", boot_loader, 1'h1);
        xrst;
        chk("boot", boot_loader, 1'h0);
        rd(ADDR_AUX_FLAGS);
        chk("swf", v[7], 1'h1);
        wr(ADDR_AUX_FLAGS, 8'h00);
        rd(ADDR_AUX_FLAGS);
        chk("swf", v[7], 1'h0);
        uwr(ADDR_BOOT_CONFIG, 8'h7F);
        xrst;
        chk("boot", boot_loader, 1'h1);
        rd(ADDR_CHIP_CONTROL);
        chk("bsel", v[1], 1'h1);
        uwr(ADDR_BOOT_CONFIG, 8'hFF);
        $display("boot select test done");
    endtask

    // timeout is 64 ticks of 2 cycles plus a short grace
    task t_wdt;
        wr(ADDR_WATCHDOG_PRESC, 8'h00);
        uwr(ADDR_WATCHDOG_CTRL, 8'h80);
        repeat (3)
        begin
            repeat (100) @(posedge clk);
            uwr(ADDR_WATCHDOG_CTRL, 8'hC0);
            #1 chk("cleared", sys_reset, 1'h0);
        end
        n = 0;
        while (sys_reset !== 1'h1 && n < 400)
        begin
            @(posedge clk);
            #1 n++;
        end
        chk("fired", n > 100 && n < 300, 1'h1);
        if (n >= 400)
        begin
            failures++;
            close_out;
        end
        rel;
        rd(ADDR_WATCHDOG_CTRL);
        chk("wdf", v[3], 1'h1);
        xrst;
        rd(ADDR_WATCHDOG_CTRL);
        chk("wdf", v[3], 1'h1);
        uwr(ADDR_WATCHDOG_CTRL, 8'h00);
        rd(ADDR_WATCHDOG_CTRL);
        chk("wdf", v[3], 1'h0);
        $display("watchdog test done");
    endtask

    // main sequence
    initial
    begin
        srst = 1'h1;
        ext_reset_req = 1'h0;
        reg_wr = 1'h0;
        reg_rd = 1'h0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        failures = 0;
        cmp_count = 0;
        repeat (5) @(posedge clk);
        srst <= 1'h0;
        rel;
        t_por;
        t_sw;
        t_boot;
        t_wdt;
        close_out;
    end
endmodule
